// ===== logic/plmo_exec.sv
// plmo_exec: executes priority load, the four move formats and the effective-address move
// assumes: decoder supplies operand descriptors, immediates already sign-extended to 16 bits,
// displacements already sign-extended to the address width; memory answers a read next cycle
// Behaviour
// - priority load writes immediate 0..7 into the interrupt priority level field.
// - general move copies source to destination at byte or word width.
// - byte move into an address register zero-extends to a 16-bit write.
// - byte move from an address register uses only its low 8 bits.
// - byte move with address registers as both source and destination is refused.
// - immediate source may not target a stack-relative destination.
// - stack-relative operands use the selected stack pointer, never both source and dest.
// - negative flag follows the most significant bit of the written value; effective-address moves leave it unchanged.
// - null-result flag is set when the transferred value is zero; effective-address moves leave it unchanged.
// - small-immediate move takes a signed -8..+7 immediate at destination width.
// - compact move allows only byte size for register and memory operands.
// - compact move of an immediate into an address register allows byte or word.
// - compact move refuses the same byte register as source and destination.
// - compact move: only data reg 0 bytes reach address regs, low byte to second, high byte to first.
// - effective-address move writes the operand address, not memory contents.
`include "plmo_map.svh"

module plmo_exec #(
    parameter int unsigned ADDR_W = 20
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire plmo_pkg::plmo_req_t req_in,
    input wire logic [ADDR_W-1:0] src_disp_in,
    input wire logic [ADDR_W-1:0] dst_disp_in,
    output logic req_ready_out,
    output logic done_out,
    output logic illegal_out,
    output logic mem_rd_out,
    output logic mem_we_out,
    output logic mem_word_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic [15:0] mem_rdata_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic [2:0] interrupt_priority_level_out
);
    // refused at elaboration: widening a 16-bit base needs more than 16 address bits
    if (ADDR_W < 17 || ADDR_W > 32) begin : g_addr_w_check
        $error("plmo_exec: ADDR_W must lie in 17..32");
    end

    plmo_pkg::plmo_state_t state_ff, nxt_state;
    plmo_pkg::plmo_req_t q_ff, nxt_q;
    logic [ADDR_W-1:0] q_src_disp_ff, nxt_q_src_disp, q_dst_disp_ff, nxt_q_dst_disp;
    logic [15:0] data_ff [4];
    logic [15:0] nxt_data [4];
    logic [15:0] addr_ff [2];
    logic [15:0] nxt_addr [2];
    logic [15:0] static_ff, nxt_static, frame_ff, nxt_frame;
    logic [15:0] ustack_ff, nxt_ustack, istack_ff, nxt_istack;
    logic stack_sel_ff, nxt_stack_sel, neg_ff, nxt_neg, zero_ff, nxt_zero;
    logic [2:0] prio_ff, nxt_prio;
    logic done_ff, nxt_done, illegal_ff, nxt_illegal;
    logic mem_rd_ff, nxt_mem_rd, mem_we_ff, nxt_mem_we, mem_word_ff, nxt_mem_word;
    logic [ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
    logic [15:0] mem_wdata_ff, nxt_mem_wdata, rdata_ff, nxt_rdata;
    logic legal, src_mem, commit;
    logic [15:0] res;
    logic [ADDR_W-1:0] src_ea, dst_ea;

    plmo_flag_if fi ();
    plmo_flags u_flags (.fi(fi));

    function automatic logic [ADDR_W-1:0] widen(input logic [15:0] v);
        widen = {{(ADDR_W-16){1'b0}}, v};
    endfunction

    // base plus displacement; the stack base follows the stack-select flag
    function automatic logic [ADDR_W-1:0] ea_of(input plmo_pkg::plmo_base_t b,
                                                  input logic [ADDR_W-1:0] d);
        logic [15:0] base;
        base = 16'h0000;
        unique case (b)
            plmo_pkg::BASE_ADDR_FIRST: base = addr_ff[0];
            plmo_pkg::BASE_ADDR_SECOND: base = addr_ff[1];
            plmo_pkg::BASE_STATIC: base = static_ff;
            plmo_pkg::BASE_FRAME: base = frame_ff;
            plmo_pkg::BASE_STACK: base = stack_sel_ff ? ustack_ff : istack_ff;
            plmo_pkg::BASE_ABS: base = 16'h0000;
            default: base = 16'h0000;
        endcase
        ea_of = widen(base) + d;
    endfunction

    // byte lanes: idx 0/1 are low/high of data reg 0, idx 2/3 of data reg 1
    function automatic logic [15:0] rd_data(input logic [1:0] idx, input logic word);
        logic [15:0] w;
        w = data_ff[{1'b0, idx[1]}];
        if (word) begin
            rd_data = data_ff[idx];
        end else begin
            rd_data = idx[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end
    endfunction

    function automatic logic is_stack(input plmo_pkg::plmo_opnd_t o);
        is_stack = (o.kind == plmo_pkg::OPK_MEM) && (o.base == plmo_pkg::BASE_STACK);
    endfunction

    always_comb begin
        legal = 1'b1;
        unique case (q_ff.op)
            plmo_pkg::OP_PRIO_LOAD: begin
                legal = (q_ff.src.kind == plmo_pkg::OPK_IMM) && (q_ff.imm <= `PLMO_PRIO_MAX);
            end
            plmo_pkg::OP_MOVE_G: begin
                if (!q_ff.word && q_ff.src.kind == plmo_pkg::OPK_ADDR &&
                    q_ff.dst.kind == plmo_pkg::OPK_ADDR) begin
                    legal = 1'b0;
                end
                if (q_ff.src.kind == plmo_pkg::OPK_IMM && is_stack(q_ff.dst)) begin
                    legal = 1'b0;
                end
                if (is_stack(q_ff.src) && is_stack(q_ff.dst)) begin
                    legal = 1'b0;
                end
                if (q_ff.dst.kind == plmo_pkg::OPK_IMM) begin
                    legal = 1'b0;
                end
            end
            plmo_pkg::OP_MOVE_Q: begin
                legal = (q_ff.src.kind == plmo_pkg::OPK_IMM) &&
                        ($signed(q_ff.imm) >= $signed(`PLMO_QIMM_MIN)) &&
                        ($signed(q_ff.imm) <= $signed(`PLMO_QIMM_MAX)) &&
                        (q_ff.dst.kind != plmo_pkg::OPK_IMM) && !is_stack(q_ff.dst);
            end
            plmo_pkg::OP_MOVE_S: begin
                if (q_ff.dst.kind == plmo_pkg::OPK_IMM || is_stack(q_ff.src) ||
                    is_stack(q_ff.dst)) begin
                    legal = 1'b0;
                end else if (q_ff.src.kind == plmo_pkg::OPK_IMM) begin
                    // immediate into an address register may be byte or word
                    legal = q_ff.dst.kind == plmo_pkg::OPK_ADDR || !q_ff.word;
                end else begin
                    if (q_ff.word) begin
                        legal = 1'b0;
                    end
                    if (q_ff.src.kind == plmo_pkg::OPK_DATA && q_ff.dst.kind == plmo_pkg::OPK_DATA
                        && q_ff.src.idx == q_ff.dst.idx) begin
                        legal = 1'b0;
                    end
                    if (q_ff.dst.kind == plmo_pkg::OPK_ADDR &&
                        !(q_ff.src.kind == plmo_pkg::OPK_DATA && q_ff.src.idx[1] == 1'b0 &&
                          q_ff.dst.idx[0] == ~q_ff.src.idx[0])) begin
                        legal = 1'b0;
                    end
                end
            end
            plmo_pkg::OP_MOVE_Z: begin
                legal = (q_ff.dst.kind != plmo_pkg::OPK_IMM) && !is_stack(q_ff.dst);
            end
            plmo_pkg::OP_EA_MOVE: begin
                legal = (q_ff.src.kind == plmo_pkg::OPK_MEM) && !is_stack(q_ff.src) &&
                        (q_ff.dst.kind == plmo_pkg::OPK_DATA || q_ff.dst.kind == plmo_pkg::OPK_ADDR);
            end
            default: legal = 1'b0;
        endcase
    end

    always_comb begin
        src_ea = ea_of(q_ff.src.base, q_src_disp_ff);
        dst_ea = ea_of(q_ff.dst.base, q_dst_disp_ff);
        src_mem = (q_ff.src.kind == plmo_pkg::OPK_MEM) && (q_ff.op == plmo_pkg::OP_MOVE_G ||
                  q_ff.op == plmo_pkg::OP_MOVE_S);
        res = 16'h0000;
        unique case (q_ff.src.kind)
            plmo_pkg::OPK_DATA: res = rd_data(q_ff.src.idx, q_ff.word);
            plmo_pkg::OPK_ADDR: begin
                res = q_ff.word ? addr_ff[q_ff.src.idx[0]] :
                      {8'h00, addr_ff[q_ff.src.idx[0]][7:0]};
            end
            plmo_pkg::OPK_MEM: res = q_ff.word ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
            plmo_pkg::OPK_IMM: res = q_ff.word ? q_ff.imm : {8'h00, q_ff.imm[7:0]};
        endcase
        if (q_ff.op == plmo_pkg::OP_MOVE_Z) begin
            res = 16'h0000;
        end
        if (q_ff.op == plmo_pkg::OP_EA_MOVE) begin
            res = src_ea[15:0];
        end
        // a byte landing in an address register is judged as the 16-bit word written
        fi.value = res;
        fi.byte_sel = !q_ff.word && q_ff.dst.kind != plmo_pkg::OPK_ADDR &&
                      q_ff.op != plmo_pkg::OP_EA_MOVE;
        commit = (state_ff == plmo_pkg::ST_EXEC && !(legal && src_mem)) ||
                 (state_ff == plmo_pkg::ST_WAIT);
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_q = q_ff;
        nxt_q_src_disp = q_src_disp_ff;
        nxt_q_dst_disp = q_dst_disp_ff;
        nxt_data = data_ff;
        nxt_addr = addr_ff;
        nxt_static = static_ff;
        nxt_frame = frame_ff;
        nxt_ustack = ustack_ff;
        nxt_istack = istack_ff;
        nxt_stack_sel = stack_sel_ff;
        nxt_neg = neg_ff;
        nxt_zero = zero_ff;
        nxt_prio = prio_ff;
        nxt_done = 1'b0;
        nxt_illegal = 1'b0;
        nxt_mem_rd = 1'b0;
        nxt_mem_we = 1'b0;
        nxt_mem_word = mem_word_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_rdata = 16'h0000;
        // software access goes first so an instruction committing the same cycle wins
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `PLMO_RIX_DATA0, `PLMO_RIX_DATA1, `PLMO_RIX_DATA2, `PLMO_RIX_DATA3:
                    nxt_data[reg_addr_in[1:0]] = reg_wdata_in;
                `PLMO_RIX_ADDR_FIRST, `PLMO_RIX_ADDR_SECOND:
                    nxt_addr[reg_addr_in[0]] = reg_wdata_in;
                `PLMO_RIX_STATIC: nxt_static = reg_wdata_in;
                `PLMO_RIX_FRAME: nxt_frame = reg_wdata_in;
                `PLMO_RIX_USER_STACK: nxt_ustack = reg_wdata_in;
                `PLMO_RIX_INTR_STACK: nxt_istack = reg_wdata_in;
                `PLMO_RIX_FLAGS: begin
                    nxt_stack_sel = reg_wdata_in[`PLMO_FLG_STACK_SEL];
                    nxt_neg = reg_wdata_in[`PLMO_FLG_NEG];
                    nxt_zero = reg_wdata_in[`PLMO_FLG_ZERO];
                    nxt_prio = reg_wdata_in[`PLMO_FLG_PRIO_HI:`PLMO_FLG_PRIO_LO];
                end
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `PLMO_RIX_DATA0, `PLMO_RIX_DATA1, `PLMO_RIX_DATA2, `PLMO_RIX_DATA3:
                    nxt_rdata = data_ff[reg_addr_in[1:0]];
                `PLMO_RIX_ADDR_FIRST, `PLMO_RIX_ADDR_SECOND: nxt_rdata = addr_ff[reg_addr_in[0]];
                `PLMO_RIX_STATIC: nxt_rdata = static_ff;
                `PLMO_RIX_FRAME: nxt_rdata = frame_ff;
                `PLMO_RIX_USER_STACK: nxt_rdata = ustack_ff;
                `PLMO_RIX_INTR_STACK: nxt_rdata = istack_ff;
                `PLMO_RIX_FLAGS: begin
                    nxt_rdata[`PLMO_FLG_STACK_SEL] = stack_sel_ff;
                    nxt_rdata[`PLMO_FLG_NEG] = neg_ff;
                    nxt_rdata[`PLMO_FLG_ZERO] = zero_ff;
                    nxt_rdata[`PLMO_FLG_PRIO_HI:`PLMO_FLG_PRIO_LO] = prio_ff;
                end
                default: nxt_rdata = 16'h0000;
            endcase
        end
        unique case (state_ff)
            plmo_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    nxt_q = req_in;
                    nxt_q_src_disp = src_disp_in;
                    nxt_q_dst_disp = dst_disp_in;
                    nxt_state = plmo_pkg::ST_EXEC;
                end
            end
            plmo_pkg::ST_EXEC: begin
                if (legal && src_mem) begin
                    nxt_mem_rd = 1'b1;
                    nxt_mem_addr = src_ea;
                    nxt_mem_word = q_ff.word;
                    nxt_state = plmo_pkg::ST_READ;
                end else begin
                    nxt_state = plmo_pkg::ST_IDLE;
                end
            end
            plmo_pkg::ST_READ: nxt_state = plmo_pkg::ST_WAIT;
            plmo_pkg::ST_WAIT: nxt_state = plmo_pkg::ST_IDLE;
        endcase
        if (commit) begin
            nxt_done = 1'b1;
            nxt_illegal = !legal;
            if (legal && q_ff.op == plmo_pkg::OP_PRIO_LOAD) begin
                nxt_prio = q_ff.imm[2:0];
            end else if (legal) begin
                unique case (q_ff.dst.kind)
                    plmo_pkg::OPK_DATA: begin
                        if (q_ff.word || q_ff.op == plmo_pkg::OP_EA_MOVE) begin
                            nxt_data[q_ff.dst.idx] = res;
                        end else if (q_ff.dst.idx[0]) begin
                            nxt_data[{1'b0, q_ff.dst.idx[1]}][15:8] = res[7:0];
                        end else begin
                            nxt_data[{1'b0, q_ff.dst.idx[1]}][7:0] = res[7:0];
                        end
                    end
                    plmo_pkg::OPK_ADDR: nxt_addr[q_ff.dst.idx[0]] = res;
                    plmo_pkg::OPK_MEM: begin
                        nxt_mem_we = 1'b1;
                        nxt_mem_addr = dst_ea;
                        nxt_mem_wdata = res;
                        nxt_mem_word = q_ff.word;
                    end
                    plmo_pkg::OPK_IMM: ;
                endcase
                if (q_ff.op != plmo_pkg::OP_EA_MOVE) begin
                    nxt_neg = fi.neg;
                    nxt_zero = fi.zero;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_ff <= plmo_pkg::ST_IDLE;
            q_ff <= '0;
            q_src_disp_ff <= '0;
            q_dst_disp_ff <= '0;
            data_ff <= '{default: `PLMO_RST_WORD};
            addr_ff <= '{default: `PLMO_RST_WORD};
            static_ff <= `PLMO_RST_WORD;
            frame_ff <= `PLMO_RST_WORD;
            ustack_ff <= `PLMO_RST_WORD;
            istack_ff <= `PLMO_RST_WORD;
            stack_sel_ff <= 1'b0;
            neg_ff <= 1'b0;
            zero_ff <= 1'b0;
            prio_ff <= `PLMO_RST_PRIO;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_word_ff <= 1'b0;
            mem_addr_ff <= '0;
            mem_wdata_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            q_ff <= nxt_q;
            q_src_disp_ff <= nxt_q_src_disp;
            q_dst_disp_ff <= nxt_q_dst_disp;
            data_ff <= nxt_data;
            addr_ff <= nxt_addr;
            static_ff <= nxt_static;
            frame_ff <= nxt_frame;
            ustack_ff <= nxt_ustack;
            istack_ff <= nxt_istack;
            stack_sel_ff <= nxt_stack_sel;
            neg_ff <= nxt_neg;
            zero_ff <= nxt_zero;
            prio_ff <= nxt_prio;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            mem_rd_ff <= nxt_mem_rd;
            mem_we_ff <= nxt_mem_we;
            mem_word_ff <= nxt_mem_word;
            mem_addr_ff <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
            rdata_ff <= nxt_rdata;
        end
    end

    assign req_ready_out = (state_ff == plmo_pkg::ST_IDLE);
    assign done_out = done_ff;
    assign illegal_out = illegal_ff;
    assign mem_rd_out = mem_rd_ff;
    assign mem_we_out = mem_we_ff;
    assign mem_word_out = mem_word_ff;
    assign mem_addr_out = mem_addr_ff;
    assign mem_wdata_out = mem_wdata_ff;
    assign reg_rdata_out = rdata_ff;
    assign interrupt_priority_level_out = prio_ff;
endmodule

// ===== logic/plmo_flag_if.sv
// plmo_flag_if: carries a result value to the flag helper and the sign/zero answer back
// assumes: purely combinational use inside one clock domain
interface plmo_flag_if;
    logic [15:0] value;
    logic byte_sel;
    logic neg;
    logic zero;
    modport calc (input value, input byte_sel, output neg, output zero);
    modport user (output value, output byte_sel, input neg, input zero);
endinterface

// ===== logic/plmo_flags.sv
// plmo_flags: sign and zero of a written value at byte or word width
// assumes: value upper byte is already zero when byte_sel is high
module plmo_flags (
    plmo_flag_if.calc fi
);
    // sign taken from the top bit of the width actually written
    assign fi.neg = fi.byte_sel ? fi.value[7] : fi.value[15];
    assign fi.zero = fi.byte_sel ? (fi.value[7:0] == 8'h00) : (fi.value == 16'h0000);
endmodule

// ===== logic/plmo_map.svh
// plmo_map.svh: offsets, field positions, reset values and limits of the move/priority unit
// assumes: included by bare name from the execution unit
`ifndef PLMO_MAP_SVH
`define PLMO_MAP_SVH

// software port indices of the register window
`define PLMO_RIX_DATA0 4'h0
`define PLMO_RIX_DATA1 4'h1
`define PLMO_RIX_DATA2 4'h2
`define PLMO_RIX_DATA3 4'h3
`define PLMO_RIX_ADDR_FIRST 4'h4
`define PLMO_RIX_ADDR_SECOND 4'h5
`define PLMO_RIX_STATIC 4'h6
`define PLMO_RIX_FRAME 4'h7
`define PLMO_RIX_USER_STACK 4'h8
`define PLMO_RIX_INTR_STACK 4'h9
`define PLMO_RIX_FLAGS 4'ha

// field positions inside the flags word
`define PLMO_FLG_STACK_SEL 0
`define PLMO_FLG_NEG 1
`define PLMO_FLG_ZERO 2
`define PLMO_FLG_PRIO_LO 4
`define PLMO_FLG_PRIO_HI 6

// reset values
`define PLMO_RST_WORD 16'h0000
`define PLMO_RST_PRIO 3'h0

// immediate limits
`define PLMO_PRIO_MAX 16'h0007
`define PLMO_QIMM_MIN 16'hfff8
`define PLMO_QIMM_MAX 16'h0007

`endif

// ===== logic/plmo_pkg.sv
// plmo_pkg: types shared by the move/priority execution unit and its testbench
// assumes: decoder delivers pre-decoded operand descriptors in these encodings
package plmo_pkg;
    typedef enum logic [2:0] {
        OP_PRIO_LOAD = 3'b000,
        OP_MOVE_G = 3'b001,
        OP_MOVE_Q = 3'b010,
        OP_MOVE_S = 3'b011,
        OP_MOVE_Z = 3'b100,
        OP_EA_MOVE = 3'b101
    } plmo_op_t;

    typedef enum logic [1:0] {
        OPK_DATA = 2'b00,
        OPK_ADDR = 2'b01,
        OPK_MEM = 2'b10,
        OPK_IMM = 2'b11
    } plmo_opk_t;

    typedef enum logic [2:0] {
        BASE_ADDR_FIRST = 3'b000,
        BASE_ADDR_SECOND = 3'b001,
        BASE_STATIC = 3'b010,
        BASE_FRAME = 3'b011,
        BASE_STACK = 3'b100,
        BASE_ABS = 3'b101
    } plmo_base_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_READ = 2'b10,
        ST_WAIT = 2'b11
    } plmo_state_t;

    typedef struct packed {
        plmo_opk_t kind;
        logic [1:0] idx;
        plmo_base_t base;
    } plmo_opnd_t;

    typedef struct packed {
        plmo_op_t op;
        logic word;
        plmo_opnd_t src;
        plmo_opnd_t dst;
        logic [15:0] imm;
    } plmo_req_t;
endpackage

// ===== tb/plmo_exec_asserts.sv
// plmo_exec_asserts: port-level timing checks of the move/priority execution unit
// assumes: bound to plmo_exec, one clock, synchronous active-low reset
module plmo_exec_asserts #(
    parameter int unsigned ADDR_W = 20
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    input wire logic illegal_out,
    input wire logic mem_rd_out,
    input wire logic mem_we_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [2:0] interrupt_priority_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    done_latency_a: assert property (req_valid_in && req_ready_out |-> ##[2:4] done_out)
        else $error("no completion within four cycles of a take");
    done_pulse_a: assert property (done_out |=> !done_out)
        else $error("completion longer than one cycle");
    illegal_done_a: assert property (illegal_out |-> done_out && !mem_we_out)
        else $error("refusal outside completion or with a store");
    store_done_a: assert property (mem_we_out |-> done_out)
        else $error("store away from completion");
    read_done_a: assert property (mem_rd_out |-> ##2 done_out && !illegal_out)
        else $error("memory read not done two cycles later");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("register read data outside its cycle");
    prio_source_a: assert property ($changed(interrupt_priority_level_out)
        |-> (done_out && !illegal_out) || $past(reg_wr_in))
        else $error("priority level moved without a load");
    addr_hold_a: assert property (!mem_rd_out && !mem_we_out |-> $stable(mem_addr_out))
        else $error("memory address moved between strobes");
endmodule
bind plmo_exec plmo_exec_asserts #(.ADDR_W(ADDR_W)) plmo_exec_asserts_inst (.clock_in,
    .reset_n_in, .req_valid_in, .req_ready_out, .done_out, .illegal_out, .mem_rd_out,
    .mem_we_out, .mem_addr_out, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .interrupt_priority_level_out);

// ===== tb/test_priority_load_and_move_ops.sv
// test_priority_load_and_move_ops: directed instruction and register-port tests
// assumes: plmo_exec at default address width, flags word at index a
module test_priority_load_and_move_ops;
    timeunit 1ns;
    timeprecision 1ps;
    localparam plmo_pkg::plmo_opnd_t d0 = '{plmo_pkg::OPK_DATA, 2'h0, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t d1 = '{plmo_pkg::OPK_DATA, 2'h1, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t d2 = '{plmo_pkg::OPK_DATA, 2'h2, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t d3 = '{plmo_pkg::OPK_DATA, 2'h3, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t a0 = '{plmo_pkg::OPK_ADDR, 2'h0, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t a1 = '{plmo_pkg::OPK_ADDR, 2'h1, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t ms = '{plmo_pkg::OPK_MEM, 2'h0, plmo_pkg::BASE_STACK};
    localparam plmo_pkg::plmo_opnd_t ma = '{plmo_pkg::OPK_MEM, 2'h0, plmo_pkg::BASE_ABS};
    localparam plmo_pkg::plmo_opnd_t mb = '{plmo_pkg::OPK_MEM, 2'h0, plmo_pkg::BASE_STATIC};
    localparam plmo_pkg::plmo_opnd_t im = '{plmo_pkg::OPK_IMM, 2'h0, plmo_pkg::BASE_ABS};
    logic clock_in, reset_n_in, req_valid_in, reg_wr_in, reg_rd_in;
    logic req_ready_out, done_out, illegal_out, mem_rd_out, mem_we_out, mem_word_out;
    plmo_pkg::plmo_req_t req_in;
    logic [19:0] disp_drv, disp, mem_addr_out;
    logic [15:0] mem_rdata_in, mem_val, reg_wdata_in, mem_wdata_out, reg_rdata_out;
    logic [3:0] reg_addr_in;
    logic [2:0] interrupt_priority_level_out;
    int n_mismatch, checked, cycles;
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %0t: got %h want %h", $time, got, exp); end end
    plmo_exec plmo_exec_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .src_disp_in(disp_drv),
        .dst_disp_in(disp_drv), .req_ready_out(req_ready_out), .done_out(done_out),
        .illegal_out(illegal_out), .mem_rd_out(mem_rd_out), .mem_we_out(mem_we_out),
        .mem_word_out(mem_word_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .interrupt_priority_level_out(interrupt_priority_level_out));
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // read data is true only in the cycle after the strobe, inverted elsewhere
    always @(posedge clock_in) begin
        mem_rdata_in <= mem_rd_out ? mem_val : ~mem_val;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(negedge clock_in);
        `CHK(reg_rdata_out, exp)
    endtask
    task automatic run(input plmo_pkg::plmo_op_t op, input logic w, input plmo_pkg::plmo_opnd_t s,
            input plmo_pkg::plmo_opnd_t d, input logic [15:0] imm, input logic ill);
        int n;
        @(posedge clock_in);
        req_valid_in <= 1'b1;
        req_in <= '{op, w, s, d, imm};
        disp_drv <= disp;
        @(posedge clock_in);
        req_valid_in <= 1'b0;
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (done_out !== 1'b1 && n < 8);
        `CHK({done_out, req_ready_out}, 2'b11)
        `CHK(illegal_out, ill)
    endtask
    initial begin
        {reg_wr_in, reg_rd_in, req_valid_in, reg_addr_in, reg_wdata_in} = '0;
        {req_in, disp_drv, disp, mem_val, mem_rdata_in, cycles} = '0;
        reset_n_in = 1'b0;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        reg_read(4'ha, 16'h0000);
        reg_write(4'hf, 16'hbeef);
        reg_read(4'hf, 16'h0000);
        $display("register port test done");
        for (int i = 0; i < 8; i++) begin
            run(plmo_pkg::OP_PRIO_LOAD, 1'b0, im, im, 16'(i), 1'b0);
            `CHK(interrupt_priority_level_out, 3'(i))
        end
        reg_read(4'ha, 16'h0070);
        $display("priority load test done");
        reg_write(4'h0, 16'h9280);
        run(plmo_pkg::OP_MOVE_G, 1'b1, d0, d1, 16'h0000, 1'b0);
        reg_read(4'h1, 16'h9280);
        reg_read(4'ha, 16'h0072);
        reg_write(4'h4, 16'hffff);
        run(plmo_pkg::OP_MOVE_G, 1'b0, d0, a0, 16'h0000, 1'b0);
        reg_read(4'h4, 16'h0080);
        reg_read(4'ha, 16'h0070);
        reg_write(4'h5, 16'hab00);
        run(plmo_pkg::OP_MOVE_G, 1'b0, a1, d2, 16'h0000, 1'b0);
        reg_read(4'h1, 16'h9200);
        reg_read(4'ha, 16'h0074);
        run(plmo_pkg::OP_MOVE_G, 1'b0, a0, a1, 16'h0000, 1'b1);
        run(plmo_pkg::OP_MOVE_G, 1'b1, im, ms, 16'h0001, 1'b1);
        run(plmo_pkg::OP_MOVE_G, 1'b1, ms, ms, 16'h0000, 1'b1);
        reg_read(4'ha, 16'h0074);
        reg_write(4'h8, 16'h0100);
        reg_write(4'h9, 16'h0200);
        reg_write(4'ha, 16'h0071);
        disp = 20'h00005;
        run(plmo_pkg::OP_MOVE_G, 1'b1, d0, ms, 16'h0000, 1'b0);
        `CHK({mem_we_out, mem_addr_out, mem_wdata_out}, {1'b1, 20'h00105, 16'h9280})
        reg_write(4'ha, 16'h0070);
        run(plmo_pkg::OP_MOVE_G, 1'b0, d0, ms, 16'h0000, 1'b0);
        `CHK({mem_we_out, mem_word_out, mem_addr_out}, {2'b10, 20'h00205})
        disp = 20'h00300;
        mem_val = 16'h00c5;
        run(plmo_pkg::OP_MOVE_G, 1'b0, ma, d3, 16'h0000, 1'b0);
        reg_read(4'h1, 16'hc500);
        $display("general move test done");
        run(plmo_pkg::OP_MOVE_Q, 1'b1, im, d2, 16'hfff8, 1'b0);
        reg_read(4'h2, 16'hfff8);
        run(plmo_pkg::OP_MOVE_Q, 1'b1, im, d2, 16'h0008, 1'b1);
        run(plmo_pkg::OP_MOVE_Q, 1'b1, im, d2, 16'hfff7, 1'b1);
        run(plmo_pkg::OP_MOVE_Q, 1'b0, im, d0, 16'h0007, 1'b0);
        reg_read(4'h0, 16'h9207);
        run(plmo_pkg::OP_MOVE_S, 1'b1, d0, d2, 16'h0000, 1'b1);
        run(plmo_pkg::OP_MOVE_S, 1'b0, d0, d0, 16'h0000, 1'b1);
        run(plmo_pkg::OP_MOVE_S, 1'b0, d0, a0, 16'h0000, 1'b1);
        run(plmo_pkg::OP_MOVE_S, 1'b0, d1, a0, 16'h0000, 1'b0);
        reg_read(4'h4, 16'h0092);
        run(plmo_pkg::OP_MOVE_S, 1'b1, im, a1, 16'h1234, 1'b0);
        reg_read(4'h5, 16'h1234);
        $display("short format test done");
        reg_write(4'h6, 16'h0400);
        disp = 20'h00010;
        run(plmo_pkg::OP_EA_MOVE, 1'b1, mb, a0, 16'h0000, 1'b0);
        reg_read(4'h4, 16'h0410);
        run(plmo_pkg::OP_MOVE_Z, 1'b0, im, d1, 16'h0000, 1'b0);
        reg_read(4'h0, 16'h0007);
        reg_read(4'ha, 16'h0074);
        $display("address and clear test done");
        print_verdict();
    end
endmodule
